/* pkg/spr_regs.svh */
// register offsets, field positions, reset values and widths of the receive path register bank
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

`define SPR_ADDR_W 12
`define SPR_OFS_OSC_CAL 12'h29a
`define SPR_OFS_CP_LVL 12'h29c
`define SPR_OFS_OSC_TUNE0 12'h29f
`define SPR_OFS_OSC_TUNE1 12'h2a0
`define SPR_OFS_TERM1 12'h2a7
`define SPR_OFS_TERM2 12'h2ae
`define SPR_OFS_RXCTL0 12'h300
`define SPR_OFS_RXCTL1 12'h301

`define SPR_RST_OSC_CAL 8'hfe
`define SPR_RST_CP_LVL 8'h17
`define SPR_RST_OSC_TUNE0 8'h33
`define SPR_RST_OSC_TUNE1 8'h08
`define SPR_RST_TERM 8'h00
`define SPR_RST_RXCTL0 8'h00
`define SPR_RST_RXCTL1 8'h01

`define SPR_MASK_OSC_CAL 8'hff
`define SPR_MASK_CP_LVL 8'h7f
`define SPR_MASK_OSC_TUNE0 8'h7f
`define SPR_MASK_OSC_TUNE1 8'h0f
`define SPR_MASK_TERM 8'h01
`define SPR_MASK_RXCTL0 8'h7f
`define SPR_MASK_RXCTL1 8'h07

`define SPR_BIT_TERM_START 0
`define SPR_BIT_SUM_METHOD 6
`define SPR_BIT_TWO_LINK 3
`define SPR_BIT_MAP_SEL 2
`define SPR_BIT_EN0 0
`define SPR_BIT_EN1 1

`endif

/* pkg/spr_pkg.sv */
// types shared by the receive path register bank
package spr_pkg;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [11:0] addr;
    logic [7:0] wdata;
  } spr_req_t;

  typedef struct packed {
    logic param_sum_method;
    logic two_link_select;
    logic link_map_select;
    logic [1:0] link_bringup_enables;
    logic [2:0] subclass;
  } spr_rxcfg_t;

  typedef struct packed {
    logic [7:0] osc_cal;
    logic [6:0] cp_level;
    logic [6:0] osc_tune0;
    logic [3:0] osc_tune1;
  } spr_analog_t;

  typedef enum logic [0:0] {
    SPR_SUM_FIELDS = 1'b0,
    SPR_SUM_OCTETS = 1'b1
  } spr_sum_t;

endpackage

/* src/spr_regbank.sv */
// receive path register bank: calibration, tuning and link receiver control
`timescale 1ns/1ps
`include "spr_regs.svh"

module spr_regbank (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire spr_pkg::spr_req_t req,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic term_cal_start_block1,
  output logic term_cal_start_block2,
  output spr_pkg::spr_rxcfg_t rxcfg,
  output spr_pkg::spr_sum_t sum_method,
  output logic link0_register_set,
  output logic link1_register_set,
  output logic [1:0] link_active,
  output spr_pkg::spr_analog_t analog
);
  import spr_pkg::*;

  logic [7:0] osc_cal_q;
  logic [7:0] cp_lvl_q;
  logic [7:0] tune0_q;
  logic [7:0] tune1_q;
  logic [7:0] term1_q;
  logic [7:0] term2_q;
  logic [7:0] rxctl0_q;
  logic [7:0] rxctl1_q;
  logic [7:0] osc_cal_d;
  logic [7:0] cp_lvl_d;
  logic [7:0] tune0_d;
  logic [7:0] tune1_d;
  logic [7:0] term1_d;
  logic [7:0] term2_d;
  logic [7:0] rxctl0_d;
  logic [7:0] rxctl1_d;
  logic term1_prev_q;
  logic term2_prev_q;
  logic [7:0] rdata_d;
  logic [7:0] wr_sel;
  logic [7:0] rd_sel;
  logic wr_take;
  logic rd_take;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, one bit per register
  function automatic logic [7:0] decode(input logic [11:0] a);
    decode = 8'h00;
    case (a)
      `SPR_OFS_OSC_CAL: decode = 8'h01;
      `SPR_OFS_CP_LVL: decode = 8'h02;
      `SPR_OFS_OSC_TUNE0: decode = 8'h04;
      `SPR_OFS_OSC_TUNE1: decode = 8'h08;
      `SPR_OFS_TERM1: decode = 8'h10;
      `SPR_OFS_TERM2: decode = 8'h20;
      `SPR_OFS_RXCTL0: decode = 8'h40;
      `SPR_OFS_RXCTL1: decode = 8'h80;
      default: decode = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (wd & mask) | (old & ~mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // strobes gated by clock enable
  always_comb begin
    wr_take = clk_en & req.wr_en;
    rd_take = clk_en & req.rd_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register select for writes and reads
  always_comb begin
    wr_sel = wr_take ? decode(req.addr) : 8'h00;
    rd_sel = decode(req.addr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next register values; read-only bits keep their reset value
  always_comb begin
    osc_cal_d = merge(osc_cal_q, req.wdata, `SPR_MASK_OSC_CAL);
    cp_lvl_d = merge(cp_lvl_q, req.wdata, `SPR_MASK_CP_LVL);
    tune0_d = merge(tune0_q, req.wdata, `SPR_MASK_OSC_TUNE0);
    tune1_d = merge(tune1_q, req.wdata, `SPR_MASK_OSC_TUNE1);
    term1_d = merge(term1_q, req.wdata, `SPR_MASK_TERM);
    term2_d = merge(term2_q, req.wdata, `SPR_MASK_TERM);
    rxctl0_d = merge(rxctl0_q, req.wdata, `SPR_MASK_RXCTL0);
    rxctl1_d = merge(rxctl1_q, req.wdata, `SPR_MASK_RXCTL1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator calibration fields
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_cal_q <= `SPR_RST_OSC_CAL;
    end else if (wr_sel[0]) begin
      osc_cal_q <= osc_cal_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge pump level detect fields
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cp_lvl_q <= `SPR_RST_CP_LVL;
    end else if (wr_sel[1]) begin
      cp_lvl_q <= cp_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator tuning, first register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tune0_q <= `SPR_RST_OSC_TUNE0;
    end else if (wr_sel[2]) begin
      tune0_q <= tune0_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator tuning, second register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tune1_q <= `SPR_RST_OSC_TUNE1;
    end else if (wr_sel[3]) begin
      tune1_q <= tune1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination block 1 trigger
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term1_q <= `SPR_RST_TERM;
    end else if (wr_sel[4]) begin
      term1_q <= term1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination block 2 trigger
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term2_q <= `SPR_RST_TERM;
    end else if (wr_sel[5]) begin
      term2_q <= term2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link receiver control, first register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxctl0_q <= `SPR_RST_RXCTL0;
    end else if (wr_sel[6]) begin
      rxctl0_q <= rxctl0_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link receiver control, second register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxctl1_q <= `SPR_RST_RXCTL1;
    end else if (wr_sel[7]) begin
      rxctl1_q <= rxctl1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block 1 trigger history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term1_prev_q <= 1'b0;
    end else if (clk_en) begin
      term1_prev_q <= term1_q[`SPR_BIT_TERM_START];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block 1 calibration start on rising edge of trigger bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term_cal_start_block1 <= 1'b0;
    end else if (clk_en) begin
      term_cal_start_block1 <= term1_q[`SPR_BIT_TERM_START] & ~term1_prev_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block 2 trigger history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term2_prev_q <= 1'b0;
    end else if (clk_en) begin
      term2_prev_q <= term2_q[`SPR_BIT_TERM_START];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block 2 calibration start on rising edge of trigger bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      term_cal_start_block2 <= 1'b0;
    end else if (clk_en) begin
      term_cal_start_block2 <= term2_q[`SPR_BIT_TERM_START] & ~term2_prev_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data select; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_sel[0]) begin
      rdata_d = osc_cal_q;
    end
    if (rd_sel[1]) begin
      rdata_d = cp_lvl_q;
    end
    if (rd_sel[2]) begin
      rdata_d = tune0_q;
    end
    if (rd_sel[3]) begin
      rdata_d = tune1_q;
    end
    if (rd_sel[4]) begin
      rdata_d = term1_q;
    end
    if (rd_sel[5]) begin
      rdata_d = term2_q;
    end
    if (rd_sel[6]) begin
      rdata_d = rxctl0_q;
    end
    if (rd_sel[7]) begin
      rdata_d = rxctl1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read strobe, one cycle after the request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_valid <= 1'b0;
    end else if (clk_en) begin
      rdata_valid <= req.rd_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, held until the next read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd_take) begin
      rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link receiver configuration
  always_comb begin
    rxcfg.param_sum_method = rxctl0_q[`SPR_BIT_SUM_METHOD];
    rxcfg.two_link_select = rxctl0_q[`SPR_BIT_TWO_LINK];
    rxcfg.link_map_select = rxctl0_q[`SPR_BIT_MAP_SEL];
    rxcfg.link_bringup_enables = {rxctl0_q[`SPR_BIT_EN1], rxctl0_q[`SPR_BIT_EN0]};
    rxcfg.subclass = rxctl1_q[2:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checksum method and register set steering
  always_comb begin
    sum_method = rxctl0_q[`SPR_BIT_SUM_METHOD] ? SPR_SUM_OCTETS : SPR_SUM_FIELDS;
    link0_register_set = ~rxctl0_q[`SPR_BIT_MAP_SEL];
    link1_register_set = rxctl0_q[`SPR_BIT_MAP_SEL];
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-link bring-up; link 1 only in dual link
  always_comb begin
    link_active[0] = rxctl0_q[`SPR_BIT_EN0];
    link_active[1] = rxctl0_q[`SPR_BIT_EN1] & rxctl0_q[`SPR_BIT_TWO_LINK];
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog tuning fields
  always_comb begin
    analog.osc_cal = osc_cal_q;
    analog.cp_level = cp_lvl_q[6:0];
    analog.osc_tune0 = tune0_q[6:0];
    analog.osc_tune1 = tune1_q[3:0];
  end

endmodule

/* verification/spr_regbank_chk.sv */
// assertions on the register bank ports
`timescale 1ns/1ps
`include "spr_regs.svh"
module spr_regbank_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire spr_pkg::spr_req_t req,
  input wire logic rdata_valid,
  input wire logic term_cal_start_block1,
  input wire logic term_cal_start_block2,
  input wire spr_pkg::spr_rxcfg_t rxcfg,
  input wire spr_pkg::spr_sum_t sum_method,
  input wire logic link0_register_set,
  input wire logic link1_register_set,
  input wire logic [1:0] link_active
);
  import spr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  rd_valid_a: assert property (clk_en && req.rd_en |=> rdata_valid)
    else $error("no read valid");
  term1_cause_a: assert property ($rose(term_cal_start_block1) |->
    $past(req.wr_en && req.addr == `SPR_OFS_TERM1 && req.wdata[0], 2)) else $error("bad start 1");
  term2_cause_a: assert property ($rose(term_cal_start_block2) |->
    $past(req.wr_en && req.addr == `SPR_OFS_TERM2 && req.wdata[0], 2)) else $error("bad start 2");
  term_once_a: assert property (clk_en && term_cal_start_block1 |=> !term_cal_start_block1)
    else $error("long start");
  link_act_a: assert property (link_active == {rxcfg.link_bringup_enables[1]
    & rxcfg.two_link_select, rxcfg.link_bringup_enables[0]}) else $error("bad link enable");
  map_sel_a: assert property (link1_register_set == rxcfg.link_map_select
    && link0_register_set != link1_register_set) else $error("bad map");
  sum_sel_a: assert property (logic'(sum_method) == rxcfg.param_sum_method)
    else $error("bad sum method");
  dual_wr_a: assert property (clk_en && req.wr_en && req.addr == `SPR_OFS_RXCTL0 |=>
    rxcfg.two_link_select == $past(req.wdata[3])) else $error("bad dual link");
  cover property (rdata_valid);
  cover property (term_cal_start_block2);
  cover property (link_active == 2'h3);
endmodule
bind spr_regbank spr_regbank_chk spr_regbank_chk_inst (.clk, .reset, .clk_en, .req,
  .rdata_valid, .term_cal_start_block1, .term_cal_start_block2, .rxcfg, .sum_method,
  .link0_register_set, .link1_register_set, .link_active);

/* verification/tb_spr_regbank.sv */
// self-checking bench for the register bank
`timescale 1ns/1ps
module tb_spr_regbank;
  import spr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  spr_req_t req = '0;
  logic [7:0] rdata;
  logic rdata_valid, t1, t2, s0, s1;
  logic [1:0] link_active;
  spr_rxcfg_t rxcfg;
  spr_sum_t sum_method;
  spr_analog_t analog;
  int failures = 0;
  int checks = 0;
  logic [11:0] ad[8] = '{12'h29a, 12'h29c, 12'h29f, 12'h2a0, 12'h2a7, 12'h2ae, 12'h300, 12'h301};
  logic [7:0] rv[8] = '{8'hfe, 8'h17, 8'h33, 8'h08, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] mk[8] = '{8'hff, 8'h7f, 8'h7f, 8'h0f, 8'h01, 8'h01, 8'h7f, 8'h07};
  logic [7:0] lv[6] = '{8'h02, 8'h03, 8'h0b, 8'h4e, 8'h45, 8'h00};
  spr_regbank spr_regbank_inst (.clk, .reset, .clk_en, .req, .rdata, .rdata_valid,
    .term_cal_start_block1(t1), .term_cal_start_block2(t2), .rxcfg, .sum_method,
    .link0_register_set(s0), .link1_register_set(s1), .link_active, .analog);
  ////////////////////////////////////////////////////////////////////////////
  task automatic ck(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    req.wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req.rd_en <= 1'b0;
    #1;
    ck({7'h00, rdata_valid}, 8'h01);
    ck(rdata, e);
  endtask
  task automatic pulse(input logic [1:0] e);
    #1 ck({6'h00, t2, t1}, 8'h00);
    @(posedge clk);
    #1 ck({6'h00, t2, t1}, {6'h00, e});
    @(posedge clk);
    #1 ck({6'h00, t2, t1}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd(ad[i], rv[i]);
    ck({6'h00, link_active}, 8'h00);
    ck(analog.osc_cal, 8'hfe);
    ck({1'b0, analog.cp_level}, 8'h17);
    ck({1'b0, analog.osc_tune0}, 8'h33);
    ck({4'h0, analog.osc_tune1}, 8'h08);
    ck({5'h00, rxcfg.subclass}, 8'h01);
    $display("test reset values done");
  endtask
  task automatic t_rw;
    for (int i = 0; i < 8; i++) begin
      wr(ad[i], 8'hff);
      rd(ad[i], mk[i]);
      wr(ad[i], 8'h00);
      rd(ad[i], 8'h00);
    end
    wr(12'h2a1, 8'hff);
    rd(12'h2a1, 8'h00);
    $display("test access kinds done");
  endtask
  task automatic t_term;
    for (int b = 0; b < 2; b++) begin
      wr(ad[4 + b], 8'h01);
      pulse(2'h1 << b);
      wr(ad[4 + b], 8'h01);
      pulse(2'h0);
      wr(ad[4 + b], 8'h00);
      pulse(2'h0);
      wr(ad[4 + b], 8'h01);
      pulse(2'h1 << b);
    end
    $display("test calibration start done");
  endtask
  task automatic t_link;
    logic [7:0] v;
    wr(12'h301, 8'h00);
    #1 ck({5'h00, rxcfg.subclass}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = lv[i];
      wr(12'h300, v);
      #1 ck({logic'(sum_method), s1, s0, rxcfg.two_link_select, 2'h0, link_active},
        {v[6], v[2], !v[2], v[3], 2'h0, v[1] & v[3], v[0]});
      rd(12'h300, v);
    end
    $display("test link control done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_rw();
    t_term();
    t_link();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
